// ### verilog/acquisition_parameter_limits.sv
// Behaviour
// - Every sample occupies one byte, so the byte footprint of a recording equals its sample count.
// - A programmed sample rate above 100 MS/s switches the block into interlaced operation.
// - Interlaced operation merges two half-period-offset converters into one sample stream.
// - Largest total count is the installed capacity divided by one, two or four active channels.
// - Smallest total count is 8 normally and 16 interlaced.
// - Post-event count is at least 4 (8 interlaced) and at most 8G less one step in single and FIFO modes; FIFO single mode leaves it unchecked.
// - Pre-event maximum is 16k-32, 8k-16 or 4k-8 for one, two or four channels.
// - In FIFO modes the repeat count spans 0 to 4G-1, with 0 meaning record until stopped.
// - Segment length in multi modes is at least 8 (16 interlaced) and at most half the per-channel capacity.
// - Post-event maximum is half the per-channel capacity less a step in standard multi, the per-channel capacity less a step in standard gate.
// - Interlaced operation doubles every minimum and every step but keeps the pre-event maxima.
// - Capacity-dependent maxima scale with the installed memory.
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module acquisition_parameter_limits #(
  parameter logic [acq_limits_pkg::CW-1:0] MEM_SAMPLES = acq_limits_pkg::MEM_DEFAULT
) (
  input  wire logic                           i_clk,
  input  wire logic                           i_sys_rst,
  input  wire logic [acq_limits_pkg::AW-1:0]  avs_address,
  input  wire logic                           avs_read,
  input  wire logic                           avs_write,
  input  wire logic [acq_limits_pkg::DW-1:0]  avs_writedata,
  input  wire logic [3:0]                     avs_byteenable,
  output logic      [acq_limits_pkg::DW-1:0]  avs_readdata,
  output logic                                avs_waitrequest,
  input  wire logic [7:0]                     i_conv_a_data,
  input  wire logic [7:0]                     i_conv_b_data,
  input  wire logic                           i_conv_valid,
  output logic      [15:0]                    o_stream_data,
  output logic                                o_stream_valid,
  output logic                                o_stream_pair,
  output logic                                o_running,
  output logic                                o_interlaced,
  output logic                                o_start_error
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Shifts below 64 samples run out of bits
  if (MEM_SAMPLES < 40'h00_0000_0040 || MEM_SAMPLES > acq_limits_pkg::LIM_8G)
  begin : g_mem_check
    $error("MEM_SAMPLES out of supported range");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Steps are powers of two: a mask test
  function automatic logic misaligned(input logic [acq_limits_pkg::CW-1:0] val,
                                      input logic [acq_limits_pkg::CW-1:0] step);
    misaligned = |(val & (step - 40'h00_0000_0001));
  endfunction

  function automatic logic [acq_limits_pkg::DW-1:0] merge_be(input logic [acq_limits_pkg::DW-1:0] old,
                                                            input logic [acq_limits_pkg::DW-1:0] wd,
                                                            input logic [3:0] be);
    merge_be = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        merge_be[i*8 +: 8] = wd[i*8 +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  acq_limits_pkg::cfg_type            cfg_r, cfg_nxt;
  acq_limits_pkg::err_type            err_r, err_nxt;
  logic                               run_r, run_nxt;
  logic                               il_r, il_nxt;
  logic                               wait_r, wait_nxt;
  logic [acq_limits_pkg::DW-1:0]      rdata_r, rdata_nxt;
  logic [15:0]                        sdata_r, sdata_nxt;
  logic                               svalid_r, svalid_nxt;
  logic                               spair_r, spair_nxt;

  // ----------------------------------------------------------------
  // Limit evaluation
  // ----------------------------------------------------------------
  acq_limits_pkg::err_type            chk;
  logic [acq_limits_pkg::CW-1:0]      step, min_total, per_ch, pre_eff, post_max, blk_max, pre_max;
  logic                               il, is_std, is_multi, is_gate, is_fsingle, is_ssingle;

  always_comb
  begin
    // Rate as held now decides interlace
    il         = cfg_r.rate > acq_limits_pkg::IL_RATE_MSPS;
    step       = il ? acq_limits_pkg::STEP_IL : acq_limits_pkg::STEP_NORM;
    min_total  = il ? acq_limits_pkg::MIN_TOTAL_IL : acq_limits_pkg::MIN_TOTAL_NORM;
    per_ch     = MEM_SAMPLES >> cfg_r.chsel;

    // Mode decode
    is_std     = cfg_r.mode < acq_limits_pkg::MODE_FIFO_SINGLE;
    is_multi   = cfg_r.mode == acq_limits_pkg::MODE_STD_MULTI || cfg_r.mode == acq_limits_pkg::MODE_FIFO_MULTI;
    is_gate    = cfg_r.mode == acq_limits_pkg::MODE_STD_GATE || cfg_r.mode == acq_limits_pkg::MODE_FIFO_GATE;
    is_fsingle = cfg_r.mode == acq_limits_pkg::MODE_FIFO_SINGLE;
    is_ssingle = cfg_r.mode == acq_limits_pkg::MODE_STD_SINGLE;
    // Multi modes take pre-event from the segment split
    pre_eff    = is_multi ? cfg_r.block_length - cfg_r.samples_after_event
                          : cfg_r.samples_before_event;

    // Pre-event maxima never double
    pre_max    = acq_limits_pkg::PRE_MAX_1CH >> cfg_r.chsel;

    if (is_std && is_multi)
      post_max = (per_ch >> 1) - step;
    else if (is_std && is_gate)
      post_max = per_ch - step;
    else
      post_max = acq_limits_pkg::LIM_8G - step;

    blk_max    = is_multi ? per_ch >> 1 : acq_limits_pkg::LIM_8G - acq_limits_pkg::STEP_NORM;

    // Unused counts keep their flags clear
    chk       = '0;
    chk.mode  = cfg_r.mode > acq_limits_pkg::MODE_FIFO_GATE;
    chk.chan  = &cfg_r.chsel;

    chk.total = is_std && (cfg_r.total_sample_count < min_total || cfg_r.total_sample_count > per_ch
                || misaligned(cfg_r.total_sample_count, step));
    chk.post  = !is_fsingle && (cfg_r.samples_after_event < step || cfg_r.samples_after_event > post_max
                || misaligned(cfg_r.samples_after_event, step));
    chk.pre   = !is_ssingle && ((is_multi && cfg_r.samples_after_event > cfg_r.block_length)
                || pre_eff < step || pre_eff > pre_max || misaligned(pre_eff, step));
    chk.block = (is_multi || is_fsingle) && (cfg_r.block_length < (step << 1)
                || cfg_r.block_length > blk_max || misaligned(cfg_r.block_length, step));
    // A 32-bit repeat count already covers 0 to 4G-1; 0 runs until stopped
  end

  // ----------------------------------------------------------------
  // Register bus and control
  // ----------------------------------------------------------------
  logic                          acc, wr;
  logic [acq_limits_pkg::DW-1:0] wv;

  always_comb
  begin
    cfg_nxt   = cfg_r;
    err_nxt   = err_r;
    run_nxt   = run_r;
    rdata_nxt = rdata_r;
    wv        = '0;
    il_nxt    = il;

    // Taken while waitrequest is still high
    acc       = (avs_read || avs_write) && wait_r;
    wr        = avs_write && !wait_r;
    // One wait cycle per access keeps read data coming from a flop
    wait_nxt  = !acc;

    // Read data stands while waitrequest is low
    if (acc && avs_read)
    begin
      case (avs_address)
        acq_limits_pkg::OFS_CTRL:     rdata_nxt = {31'h0000_0000, run_r};
        acq_limits_pkg::OFS_MODE:     rdata_nxt = {23'h00_0000, cfg_r.dual_rate_recording, 2'h0,
                                                   cfg_r.chsel, 1'h0, cfg_r.mode};
        acq_limits_pkg::OFS_RATE:     rdata_nxt = cfg_r.rate;
        acq_limits_pkg::OFS_STATUS:   rdata_nxt = {24'h00_0000, err_r, il_r, run_r};
        // Byte footprint equals sample count
        acq_limits_pkg::OFS_TOTAL_LO: rdata_nxt = cfg_r.total_sample_count[31:0];
        acq_limits_pkg::OFS_TOTAL_HI: rdata_nxt = {24'h00_0000, cfg_r.total_sample_count[39:32]};
        acq_limits_pkg::OFS_PRE_LO:   rdata_nxt = pre_eff[31:0];
        acq_limits_pkg::OFS_PRE_HI:   rdata_nxt = {24'h00_0000, pre_eff[39:32]};
        acq_limits_pkg::OFS_POST_LO:  rdata_nxt = cfg_r.samples_after_event[31:0];
        acq_limits_pkg::OFS_POST_HI:  rdata_nxt = {24'h00_0000, cfg_r.samples_after_event[39:32]};
        acq_limits_pkg::OFS_BLOCK_LO: rdata_nxt = cfg_r.block_length[31:0];
        acq_limits_pkg::OFS_BLOCK_HI: rdata_nxt = {24'h00_0000, cfg_r.block_length[39:32]};
        acq_limits_pkg::OFS_REPEAT:   rdata_nxt = cfg_r.repeat_count;
        default:                      rdata_nxt = '0;
      endcase
    end

    // A write lands when waitrequest is low
    if (wr)
    begin
      case (avs_address)
        acq_limits_pkg::OFS_CTRL:
        begin
          wv = avs_writedata & {32{avs_byteenable[0]}};
          // Stop wins over start
          if (wv[acq_limits_pkg::CTRL_STOP_BIT])
            run_nxt = 1'b0;
          else if (wv[acq_limits_pkg::CTRL_START_BIT])
          begin
            // Flags persist until the next start
            err_nxt = chk;
            run_nxt = chk == '0;
          end
        end
        acq_limits_pkg::OFS_MODE:
        begin
          wv = merge_be({23'h00_0000, cfg_r.dual_rate_recording, 2'h0, cfg_r.chsel, 1'h0, cfg_r.mode},
                        avs_writedata, avs_byteenable);
          cfg_nxt.mode                = wv[acq_limits_pkg::MODE_LSB +: 3];
          cfg_nxt.chsel               = wv[acq_limits_pkg::CHSEL_LSB +: 2];
          cfg_nxt.dual_rate_recording = wv[acq_limits_pkg::DUAL_RATE_BIT];
        end
        acq_limits_pkg::OFS_RATE:     cfg_nxt.rate = merge_be(cfg_r.rate, avs_writedata, avs_byteenable);
        acq_limits_pkg::OFS_TOTAL_LO: cfg_nxt.total_sample_count[31:0] =
                                        merge_be(cfg_r.total_sample_count[31:0], avs_writedata, avs_byteenable);
        // Upper words use lane 0 only
        acq_limits_pkg::OFS_TOTAL_HI: if (avs_byteenable[0])
                                        cfg_nxt.total_sample_count[39:32] = avs_writedata[7:0];
        acq_limits_pkg::OFS_PRE_LO:   cfg_nxt.samples_before_event[31:0] =
                                        merge_be(cfg_r.samples_before_event[31:0], avs_writedata, avs_byteenable);
        acq_limits_pkg::OFS_PRE_HI:   if (avs_byteenable[0])
                                        cfg_nxt.samples_before_event[39:32] = avs_writedata[7:0];
        acq_limits_pkg::OFS_POST_LO:  cfg_nxt.samples_after_event[31:0] =
                                        merge_be(cfg_r.samples_after_event[31:0], avs_writedata, avs_byteenable);
        acq_limits_pkg::OFS_POST_HI:  if (avs_byteenable[0])
                                        cfg_nxt.samples_after_event[39:32] = avs_writedata[7:0];
        acq_limits_pkg::OFS_BLOCK_LO: cfg_nxt.block_length[31:0] =
                                        merge_be(cfg_r.block_length[31:0], avs_writedata, avs_byteenable);
        acq_limits_pkg::OFS_BLOCK_HI: if (avs_byteenable[0])
                                        cfg_nxt.block_length[39:32] = avs_writedata[7:0];
        // Any 32-bit repeat count; 0 runs until stopped
        acq_limits_pkg::OFS_REPEAT:   cfg_nxt.repeat_count =
                                        merge_be(cfg_r.repeat_count, avs_writedata, avs_byteenable);
        default:                      cfg_nxt = cfg_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sample stream
  // ----------------------------------------------------------------
  always_comb
  begin
    // Beats while stopped are dropped, not kept
    svalid_nxt = run_r && i_conv_valid;
    spair_nxt  = run_r && i_conv_valid && il_r;
    sdata_nxt  = sdata_r;

    if (run_r && i_conv_valid)
    begin
      // Converter A leads B by half a sample period, so A is the older sample
      if (il_r)
        sdata_nxt = {i_conv_b_data, i_conv_a_data};
      else
        sdata_nxt = {8'h00, i_conv_a_data};
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      // Reset leaves standard single mode
      cfg_r.mode                 <= acq_limits_pkg::MODE_STD_SINGLE;
      cfg_r.chsel                <= 2'h0;
      cfg_r.dual_rate_recording  <= 1'b0;
      cfg_r.rate                 <= acq_limits_pkg::RST_RATE;
      cfg_r.total_sample_count   <= acq_limits_pkg::RST_COUNT;
      cfg_r.samples_before_event <= acq_limits_pkg::RST_POST;
      cfg_r.samples_after_event  <= acq_limits_pkg::RST_POST;
      cfg_r.block_length         <= acq_limits_pkg::RST_COUNT;
      cfg_r.repeat_count         <= acq_limits_pkg::RST_REPEAT;
      err_r                      <= '0;
      run_r                      <= 1'b0;
      il_r                       <= 1'b0;
      wait_r                     <= 1'b1;
      rdata_r                    <= '0;
      sdata_r                    <= '0;
      svalid_r                   <= 1'b0;
      spair_r                    <= 1'b0;
    end
    else
    begin
      cfg_r    <= cfg_nxt;
      err_r    <= err_nxt;
      run_r    <= run_nxt;
      il_r     <= il_nxt;
      wait_r   <= wait_nxt;
      rdata_r  <= rdata_nxt;
      sdata_r  <= sdata_nxt;
      svalid_r <= svalid_nxt;
      spair_r  <= spair_nxt;
    end
  end

  // Outputs straight from flops, except o_start_error, which is the OR of the err_r flops
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;
  assign o_stream_data   = sdata_r;
  assign o_stream_valid  = svalid_r;
  assign o_stream_pair   = spair_r;
  assign o_running       = run_r;
  assign o_interlaced    = il_r;
  assign o_start_error   = |err_r;

endmodule

`default_nettype wire

// ### shared/acq_limits_pkg.sv
package acq_limits_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int CW = 40;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int HI_W = CW - DW;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CTRL     = 8'h00;
  localparam logic [AW-1:0] OFS_MODE     = 8'h04;
  localparam logic [AW-1:0] OFS_RATE     = 8'h08;
  localparam logic [AW-1:0] OFS_STATUS   = 8'h0C;
  localparam logic [AW-1:0] OFS_TOTAL_LO = 8'h10;
  localparam logic [AW-1:0] OFS_TOTAL_HI = 8'h14;
  localparam logic [AW-1:0] OFS_PRE_LO   = 8'h18;
  localparam logic [AW-1:0] OFS_PRE_HI   = 8'h1C;
  localparam logic [AW-1:0] OFS_POST_LO  = 8'h20;
  localparam logic [AW-1:0] OFS_POST_HI  = 8'h24;
  localparam logic [AW-1:0] OFS_BLOCK_LO = 8'h28;
  localparam logic [AW-1:0] OFS_BLOCK_HI = 8'h2C;
  localparam logic [AW-1:0] OFS_REPEAT   = 8'h30;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT  = 1;
  localparam int MODE_LSB       = 0;
  localparam int CHSEL_LSB      = 4;
  localparam int DUAL_RATE_BIT  = 8;

  // ----------------------------------------------------------------
  // Limits, in samples; the interlace rate threshold in MS/s
  // ----------------------------------------------------------------
  localparam logic [CW-1:0] STEP_NORM      = 40'h00_0000_0004;
  localparam logic [CW-1:0] STEP_IL        = 40'h00_0000_0008;
  localparam logic [CW-1:0] MIN_TOTAL_NORM = 40'h00_0000_0008;
  localparam logic [CW-1:0] MIN_TOTAL_IL   = 40'h00_0000_0010;
  localparam logic [CW-1:0] LIM_8G         = 40'h02_0000_0000;
  localparam logic [CW-1:0] PRE_MAX_1CH    = 40'h00_0000_3FE0;
  localparam logic [DW-1:0] IL_RATE_MSPS   = 32'h0000_0064;
  localparam logic [CW-1:0] MEM_DEFAULT    = 40'h00_0400_0000;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CW-1:0] RST_COUNT  = 40'h00_0000_0400;
  localparam logic [CW-1:0] RST_POST   = 40'h00_0000_0200;
  localparam logic [DW-1:0] RST_RATE   = 32'h0000_0064;
  localparam logic [DW-1:0] RST_REPEAT = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_STD_SINGLE  = 3'b000,
    MODE_STD_MULTI   = 3'b001,
    MODE_STD_GATE    = 3'b010,
    MODE_FIFO_SINGLE = 3'b011,
    MODE_FIFO_MULTI  = 3'b100,
    MODE_FIFO_GATE   = 3'b101
  } rec_mode_type;

  typedef struct packed {
    logic block;
    logic post;
    logic pre;
    logic total;
    logic chan;
    logic mode;
  } err_type;

  typedef struct packed {
    logic [2:0]    mode;
    logic [1:0]    chsel;
    logic          dual_rate_recording;
    logic [DW-1:0] rate;
    logic [CW-1:0] total_sample_count;
    logic [CW-1:0] samples_before_event;
    logic [CW-1:0] samples_after_event;
    logic [CW-1:0] block_length;
    logic [DW-1:0] repeat_count;
  } cfg_type;

endpackage

// ### verif/acq_limits_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module acq_limits_monitor (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [7:0]  i_conv_a_data,
  input wire logic [7:0]  i_conv_b_data,
  input wire logic        i_conv_valid,
  input wire logic [15:0] o_stream_data,
  input wire logic        o_stream_valid,
  input wire logic        o_stream_pair,
  input wire logic        o_running,
  input wire logic        o_interlaced,
  input wire logic        o_start_error
);
  logic req;
  assign req = avs_read | avs_write;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ----------------------------------------
  // Bus handshake, status and sample stream
  // ----------------------------------------
  sequence s_taken;
    req && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  sequence s_beat;
    i_conv_valid && o_running;
  endsequence
  AST_BUS_ANSWER: assert property (s_taken |=> s_answer) else $error("bus access not answered in one cycle");
  AST_BUS_IDLE: assert property (!req |=> avs_waitrequest) else $error("waitrequest low without a request");
  AST_RESET_OUT: assert property ($fell(i_sys_rst) |-> avs_waitrequest && avs_readdata == 32'h0000_0000
    && !o_running && !o_stream_valid && !o_start_error) else $error("outputs not idle after reset");
  AST_STATUS_READ: assert property (s_taken ##0 (avs_read && avs_address == acq_limits_pkg::OFS_STATUS) |=>
    avs_readdata[1:0] == {o_interlaced, o_running} && (|avs_readdata[7:2]) == o_start_error)
    else $error("status word disagrees with status outputs");
  AST_ERR_NO_RUN: assert property (o_start_error |-> !o_running) else $error("running despite error");
  AST_STREAM_TAKE: assert property (s_beat |=> o_stream_valid) else $error("accepted beat not passed on");
  AST_STREAM_REFUSE: assert property (!(i_conv_valid && o_running) |=> !o_stream_valid)
    else $error("beat passed on while idle");
  AST_STREAM_BYTE: assert property (o_stream_valid && !o_stream_pair |->
    o_stream_data == {8'h00, $past(i_conv_a_data)}) else $error("single sample word wrong");
  AST_STREAM_PAIR: assert property (o_stream_valid && o_stream_pair |->
    o_stream_data == {$past(i_conv_b_data), $past(i_conv_a_data)}) else $error("paired sample word wrong");
endmodule
bind acquisition_parameter_limits acq_limits_monitor mon_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .i_conv_a_data(i_conv_a_data), .i_conv_b_data(i_conv_b_data),
  .i_conv_valid(i_conv_valid), .o_stream_data(o_stream_data), .o_stream_valid(o_stream_valid),
  .o_stream_pair(o_stream_pair), .o_running(o_running), .o_interlaced(o_interlaced),
  .o_start_error(o_start_error));
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [39:0] MEM = 40'h00_0000_0100;
  localparam longint      G8  = acq_limits_pkg::LIM_8G;
  localparam logic [7:0]  RA [0:8] = '{8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h20, 8'h28, 8'h30, 8'h40};
  localparam logic [31:0] RV [0:8] = '{32'h0, 32'h64, 32'h400, 32'h0, 32'h200, 32'h200, 32'h400, 32'h0, 32'h0};
  logic        i_clk, i_sys_rst, avs_read, avs_write, avs_waitrequest, conv_valid;
  logic [7:0]  avs_address, conv_a, conv_b;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  logic [15:0] stream_data;
  logic        stream_valid, stream_pair, running, interlaced, start_error;
  int          n_fail, samples_checked;

  acquisition_parameter_limits #(.MEM_SAMPLES(MEM)) dut_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .i_conv_a_data(conv_a), .i_conv_b_data(conv_b), .i_conv_valid(conv_valid), .o_stream_data(stream_data),
    .o_stream_valid(stream_valid), .o_stream_pair(stream_pair), .o_running(running),
    .o_interlaced(interlaced), .o_start_error(start_error));

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // ----------------------------------------
  // Bus cycles and expected limits
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    @(posedge i_clk);
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 20) chk("bus_wait", 40'h1, 40'h0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr40(input logic [7:0] a, input longint v);
    bus(1'b1, a, v[31:0]);
    bus(1'b1, a + 8'h04, {24'h000000, v[39:32]});
  endtask

  // Unused counts of a mode are left out; with an illegal mode or channel code only that code's own flag is compared
  function automatic logic [5:0] exp_err(input int m, c, il, input longint tot, pre, post, blk,
                                         output logic [5:0] mk);
    longint     s, cap, p, qmax;
    logic [5:0] e;
    s = il ? 8 : 4;
    cap = longint'(MEM) >> c;
    p = (m == 1 || m == 4) ? blk - post : pre;
    qmax = (m == 1) ? (cap >> 1) - s : (m == 2) ? cap - s : G8 - s;
    e = {5'h00, m > 5};
    e[1] = c == 3;
    if (m <= 2) e[2] = tot < 2 * s || tot > cap || tot % s != 0;
    if (m != 0) e[3] = p < s || p > (64'h3FE0 >> c) || p % s != 0;
    if (m != 3) e[4] = post < s || post > qmax || post % s != 0;
    if (m == 1 || m == 4) e[5] = blk < 2 * s || blk > (cap >> 1) || blk % s != 0;
    if (m == 3) e[5] = blk < 2 * s || blk > G8 - 4 || blk % s != 0;
    mk = (c == 3) ? 6'h02 : (m > 5) ? 6'h01 : (m == 3) ? 6'h2F : 6'h3F;
    return e;
  endfunction

  task automatic run_cfg(input int m, c, il, input longint tot, pre, post, blk);
    logic [5:0] e, mk;
    e = exp_err(m, c, il, tot, pre, post, blk, mk);
    bus(1'b1, acq_limits_pkg::OFS_CTRL, 32'h0000_0002);
    bus(1'b1, acq_limits_pkg::OFS_MODE, 32'((c << 4) | m));
    // Stop lands as its access ends
    chk("stopped", running, 40'h0);
    bus(1'b1, acq_limits_pkg::OFS_RATE, il ? 32'h0000_0065 : 32'h0000_0064);
    wr40(acq_limits_pkg::OFS_TOTAL_LO, tot);
    wr40(acq_limits_pkg::OFS_PRE_LO, pre);
    wr40(acq_limits_pkg::OFS_POST_LO, post);
    wr40(acq_limits_pkg::OFS_BLOCK_LO, blk);
    bus(1'b1, acq_limits_pkg::OFS_CTRL, 32'h0000_0001);
    bus(1'b0, acq_limits_pkg::OFS_STATUS, 32'h0000_0000);
    chk("err_flags", q[7:2] & mk, e & mk);
    chk("running", running, e == 6'h00);
    chk("start_error", start_error, e != 6'h00);
    chk("interlaced", {q[1], interlaced}, {2{il[0]}});
  endtask

  task automatic stream(input logic il, input logic run);
    logic [7:0] a, b;
    logic       v;
    repeat (20)
    begin
      @(posedge i_clk);
      a = 8'($urandom);
      b = 8'($urandom);
      v = 1'($urandom_range(0, 1));
      conv_a <= a;
      conv_b <= b;
      conv_valid <= v;
      @(posedge i_clk);
      conv_valid <= 1'b0;
      #1;
      chk("stream_valid", stream_valid, v & run);
      if (v & run) chk("stream_data", {stream_pair, stream_data}, il ? {1'b1, b, a} : {9'h000, a});
    end
  endtask

  initial
  begin
    #200000;
    n_fail++;
    complete_run();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int nb, sm, m;
    n_fail = 0;
    samples_checked = 0;
    i_sys_rst = 1'b1;
    {avs_read, avs_write, conv_valid} = 3'h0;
    {avs_address, conv_a, conv_b} = 24'h000000;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    void'($urandom(73109));
    repeat (16) @(posedge i_clk);
    chk("reset_out", {avs_waitrequest, running, interlaced, start_error, stream_valid}, 5'h10);
    i_sys_rst <= 1'b0;
    bus(1'b1, 8'h40, 32'hFFFF_FFFF);
    for (int i = 0; i < 9; i++)
    begin
      bus(1'b0, RA[i], 32'h0000_0000);
      chk("reset_value", q, RV[i]);
    end
    bus(1'b1, acq_limits_pkg::OFS_REPEAT, 32'hFFFF_FFFF);
    bus(1'b0, acq_limits_pkg::OFS_REPEAT, 32'h0000_0000);
    chk("repeat", q, 40'hFFFF_FFFF);
    avs_byteenable <= 4'h3;
    bus(1'b1, acq_limits_pkg::OFS_REPEAT, 32'h0000_1234);
    avs_byteenable <= 4'hF;
    bus(1'b0, acq_limits_pkg::OFS_REPEAT, 32'h0000_0000);
    chk("repeat_lanes", q, 40'hFFFF_1234);
    run_cfg(3, 0, 0, 0, 4, 0, 8);
    run_cfg(0, 0, 0, MEM, 0, 8, 0);
    run_cfg(0, 0, 0, MEM + 4, 0, 8, 0);
    run_cfg(0, 2, 0, 68, 0, 8, 0);
    run_cfg(0, 1, 1, 128, 0, 8, 0);
    run_cfg(0, 0, 0, 8, 0, 4, 0);
    run_cfg(0, 0, 0, 4, 0, 4, 0);
    run_cfg(0, 0, 1, 8, 0, 8, 0);
    run_cfg(0, 0, 0, 18, 0, 8, 0);
    run_cfg(0, 0, 0, 16, 0, G8 - 4, 0);
    run_cfg(0, 0, 1, 16, 0, G8 - 4, 0);
    run_cfg(0, 0, 1, 16, 0, 4, 0);
    run_cfg(1, 0, 0, 128, 0, 124, 128);
    run_cfg(1, 0, 0, 132, 0, 128, 132);
    run_cfg(1, 0, 1, 16, 0, 8, 16);
    run_cfg(1, 1, 0, 64, 0, 60, 64);
    run_cfg(2, 0, 0, MEM, 40'h3FE0, MEM - 4, 0);
    run_cfg(2, 0, 0, MEM, 40'h3FE4, MEM, 0);
    run_cfg(3, 0, 1, 0, 4, 0, G8);
    run_cfg(5, 1, 0, 0, 40'h1FF0, G8 - 4, 0);
    run_cfg(5, 0, 0, 0, 8, G8, 0);
    run_cfg(0, 3, 0, 16, 0, 8, 0);
    run_cfg(6, 0, 0, 16, 0, 8, 0);
    run_cfg(2, 2, 1, 64, 40'hFF8, 56, 0);
    stream(1'b1, 1'b1);
    run_cfg(4, 2, 0, 0, 0, 28, 32);
    stream(1'b0, 1'b1);
    bus(1'b1, acq_limits_pkg::OFS_CTRL, 32'h0000_0002);
    stream(1'b0, 1'b0);
    for (int k = 0; k < 30; k++)
    begin
      m = $urandom_range(0, 5);
      sm = $urandom_range(0, 1);
      nb = $urandom_range(2, 20);
      run_cfg(m, $urandom_range(0, 2), sm, (m == 1) ? nb * (4 + 4 * sm) : $urandom_range(1, 80) * 4,
              $urandom_range(1, 40) * 4, $urandom_range(1, nb - 1) * 4, nb * (4 + 4 * sm));
    end
    // A second reset in mid-run must drop the acquisition
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
    chk("reset_mid", {avs_waitrequest, running, start_error}, 3'h4);
    @(posedge i_clk);
    i_sys_rst <= 1'b0;
    bus(1'b0, acq_limits_pkg::OFS_STATUS, 32'h0000_0000);
    chk("status_after_reset", q, 40'h0);
    complete_run();
  end
endmodule
`default_nettype wire
